// File: shared/smc_pkg.sv
// package: register map, field positions and states for standby control
package smc_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   // register indices (word per index, port address = index)
   localparam logic [3:0] PWR_IDX = 4'h0;
   localparam logic [3:0] CLKSEL_IDX = 4'h1;
   localparam logic [3:0] STAT_IDX = 4'h2;
   // power save control fields
   localparam int unsigned PWR_IDLE_BIT = 0;
   localparam int unsigned PWR_HALT_BIT = 1;
   // clock selection fields
   localparam int unsigned SEL_CPU_SUB_BIT = 0;
   localparam int unsigned SEL_MAIN_STOP_BIT = 1;
   localparam int unsigned SEL_SUB_PRESENT_BIT = 2;
   localparam int unsigned SEL_NE_SUB_BIT = 3;
   localparam int unsigned SEL_TZ_WT_BIT = 4;
   localparam int unsigned SEL_WT_SUB_BIT = 5;
   localparam int unsigned SEL_T45_SUB_BIT = 6;
   localparam int unsigned SEL_SER_EXT_BIT = 7;
   localparam logic [7:0] SEL_RST = 8'h00;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [2:0] Q_FULL = 3'h4;
   localparam logic [2:0] Q_ZERO = 3'h0;
   localparam logic [2:0] Q_ONE = 3'h1;
   typedef enum logic [1:0] {
      SMC_RUN = 2'b00,
      SMC_DRAIN = 2'b01,
      SMC_HALT = 2'b10,
      SMC_IDLE = 2'b11
   } smc_state_t;
endpackage : smc_pkg

// File: src/smc_standby_ctrl.sv
// standby mode control: halt drain, idle gating, wake-up and bus hold
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
// How it works
// - halt keeps bus hold and peripherals working
// - halt fetches until prefetch queue full
// - irq six runs per noise-filter clock
// - idle gates main clock, subclock stays
// - idle exit without stabilization wait
// - idle stops execution, keeps state
// - idle stops peripherals except subclock and externally clocked ones
// - idle never acknowledges bus hold
// - idle bit enters idle mode
// - nmi, unmasked irq or reset end idle
// - timer zero runs on subclock watch interval
// - timers four/five need subclock; others stop
// - clocked serial needs external clock; two-wire stops
// - uart transmits only with external baud
// - both oscillators keep running in idle
module smc_standby_ctrl
   import smc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic nmi_req,
   input wire logic irq_req,
   input wire logic fetch_done,
   input wire logic bus_hold_request,
   output logic bus_hold_ack,
   output logic cpu_clk_en,
   output logic cpu_run,
   output logic fetch_en,
   output logic periph_clk_en,
   output logic main_osc_en,
   output logic sub_osc_en,
   output logic sub_clk_en,
   output logic ext_irq_six_en,
   output logic timer_zero_en,
   output logic timer_four_en,
   output logic timer_five_en,
   output logic timer_other_en,
   output logic clocked_serial_port_en,
   output logic twowire_serial_en,
   output logic uart_tx_en,
   output logic uart_rx_en,
   output logic watch_timer_en,
   output logic watchdog_en,
   output logic conv_dma_can_en,
   output logic port_hold,
   output logic bus_pins_hiz
);

   // ************************************************
   // registers
   // ************************************************
   logic [DATA_W-1:0] power_save_control_reg;
   logic [DATA_W-1:0] clk_sel_r;
   logic [2:0] queue_cnt_r;
   smc_state_t state_r;
   smc_state_t state_nxt;
   logic wake;

   function automatic logic sel(input logic [DATA_W-1:0] v,
                                input int unsigned b);
      sel = v[b];
   endfunction : sel

   assign wake = nmi_req | irq_req;

   // ************************************************
   // register port
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         power_save_control_reg <= ZERO8;
      end else if (reg_wr && reg_addr == PWR_IDX && state_r == SMC_RUN) begin
         power_save_control_reg <= reg_wdata;
      end else if (state_r != SMC_RUN) begin
         // mode bits self-clear once the mode is taken
         power_save_control_reg <= ZERO8;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clk_sel_r <= SEL_RST;
      end else if (reg_wr && reg_addr == CLKSEL_IDX) begin
         clk_sel_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= ZERO8;
      end else if (reg_rd) begin
         case (reg_addr)
            PWR_IDX: reg_rdata <= power_save_control_reg;
            CLKSEL_IDX: reg_rdata <= clk_sel_r;
            STAT_IDX: reg_rdata <= {3'b000, queue_cnt_r, state_r};
            default: reg_rdata <= ZERO8;
         endcase
      end else begin
         reg_rdata <= ZERO8;
      end
   end

   // ************************************************
   // mode sequencer
   // ************************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SMC_RUN: begin
            if (sel(power_save_control_reg, PWR_IDLE_BIT)) begin
               state_nxt = SMC_IDLE;
            end else if (sel(power_save_control_reg, PWR_HALT_BIT)) begin
               state_nxt = SMC_DRAIN;
            end
         end
         SMC_DRAIN: begin
            if (queue_cnt_r == Q_FULL) begin
               state_nxt = SMC_HALT;
            end
         end
         SMC_HALT: begin
            if (wake) begin
               state_nxt = SMC_RUN;
            end
         end
         SMC_IDLE: begin
            // no stabilization count: straight back to run
            if (wake) begin
               state_nxt = SMC_RUN;
            end
         end
         default: state_nxt = SMC_RUN;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r <= SMC_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // prefetch queue fill count during drain
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         queue_cnt_r <= Q_ZERO;
      end else if (state_r == SMC_DRAIN) begin
         if (fetch_done && queue_cnt_r != Q_FULL) begin
            queue_cnt_r <= queue_cnt_r + Q_ONE;
         end
      end else begin
         queue_cnt_r <= Q_ZERO;
      end
   end

   // ************************************************
   // bus hold
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_hold_ack <= 1'b0;
      end else if (state_nxt == SMC_IDLE) begin
         bus_hold_ack <= 1'b0;
      end else begin
         bus_hold_ack <= bus_hold_request;
      end
   end

   // ************************************************
   // clock and peripheral gating
   // ************************************************
   logic idle_n;
   logic run_n;
   logic on_sub;
   logic main_stop;
   logic sub_ok;
   logic ext_clk;
   assign idle_n = (state_nxt == SMC_IDLE);
   assign run_n = (state_nxt == SMC_RUN);
   assign on_sub = sel(clk_sel_r, SEL_CPU_SUB_BIT);
   assign main_stop = sel(clk_sel_r, SEL_MAIN_STOP_BIT);
   assign sub_ok = sel(clk_sel_r, SEL_SUB_PRESENT_BIT);
   assign ext_clk = sel(clk_sel_r, SEL_SER_EXT_BIT);

   // cpu side: drain still needs the core clock to keep fetching
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cpu_clk_en <= 1'b1;
         cpu_run <= 1'b1;
         fetch_en <= 1'b1;
      end else begin
         cpu_clk_en <= run_n || state_nxt == SMC_DRAIN;
         cpu_run <= run_n;
         fetch_en <= run_n || state_nxt == SMC_DRAIN;
      end
   end

   // oscillators never stop here, so wake needs no settling count
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         periph_clk_en <= 1'b1;
         main_osc_en <= 1'b1;
         sub_osc_en <= 1'b1;
         sub_clk_en <= 1'b1;
      end else begin
         periph_clk_en <= !idle_n;
         main_osc_en <= 1'b1;
         sub_osc_en <= 1'b1;
         sub_clk_en <= 1'b1;
      end
   end

   // ************************************************
   // pins
   // ************************************************
   // ports hold in every standby state; the bus floats in idle and halt
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         port_hold <= 1'b0;
         bus_pins_hiz <= 1'b0;
      end else begin
         port_hold <= !run_n;
         bus_pins_hiz <= idle_n || state_nxt == SMC_HALT;
      end
   end

   logic irq6;
   always_comb begin
      if (idle_n) begin
         irq6 = sub_ok && sel(clk_sel_r, SEL_NE_SUB_BIT);
      end else if (on_sub && main_stop) begin
         irq6 = sel(clk_sel_r, SEL_NE_SUB_BIT);
      end else if (!on_sub && !sub_ok) begin
         irq6 = !sel(clk_sel_r, SEL_NE_SUB_BIT);
      end else begin
         irq6 = 1'b1;
      end
   end

   // ************************************************
   // external interrupt six
   // ************************************************
   // the clock limits apply only once halted or idle
   // run and drain keep the input fully alive
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ext_irq_six_en <= 1'b1;
      end else if (idle_n || state_nxt == SMC_HALT) begin
         ext_irq_six_en <= irq6;
      end else begin
         ext_irq_six_en <= 1'b1;
      end
   end

   // ************************************************
   // timers
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer_zero_en <= 1'b1;
         timer_other_en <= 1'b1;
      end else if (idle_n) begin
         timer_zero_en <= sel(clk_sel_r, SEL_TZ_WT_BIT)
            && sel(clk_sel_r, SEL_WT_SUB_BIT) && sub_ok;
         timer_other_en <= 1'b0;
      end else begin
         timer_zero_en <= 1'b1;
         timer_other_en <= 1'b1;
      end
   end

   // four and five share one clock choice: one decode feeds both
   logic t45_on;
   assign t45_on = sub_ok && sel(clk_sel_r, SEL_T45_SUB_BIT);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer_four_en <= 1'b1;
         timer_five_en <= 1'b1;
      end else if (idle_n) begin
         timer_four_en <= t45_on;
         timer_five_en <= t45_on;
      end else begin
         timer_four_en <= 1'b1;
         timer_five_en <= 1'b1;
      end
   end

   // ************************************************
   // serial ports
   // ************************************************
   // an external baud clock still lets a uart send, but its receiver
   // samples on the gated main clock and so must stop
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clocked_serial_port_en <= 1'b1;
         twowire_serial_en <= 1'b1;
         uart_tx_en <= 1'b1;
         uart_rx_en <= 1'b1;
      end else if (idle_n) begin
         clocked_serial_port_en <= ext_clk;
         twowire_serial_en <= 1'b0;
         uart_tx_en <= ext_clk;
         uart_rx_en <= 1'b0;
      end else begin
         clocked_serial_port_en <= 1'b1;
         twowire_serial_en <= 1'b1;
         uart_tx_en <= 1'b1;
         uart_rx_en <= 1'b1;
      end
   end

   // ************************************************
   // watch timer, watchdog, converter, dma and can
   // ************************************************
   // watch timer sits on the subclock; bus masters would disturb the
   // ram contents that idle promises to keep
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         watch_timer_en <= 1'b1;
         watchdog_en <= 1'b1;
         conv_dma_can_en <= 1'b1;
      end else if (idle_n) begin
         watch_timer_en <= 1'b1;
         watchdog_en <= 1'b0;
         conv_dma_can_en <= 1'b0;
      end else begin
         watch_timer_en <= 1'b1;
         watchdog_en <= 1'b1;
         conv_dma_can_en <= 1'b1;
      end
   end

endmodule : smc_standby_ctrl

// File: test/smc_standby_props.sv
// checker: idle, halt and bus hold relations at the ports
`timescale 1ns/10ps
// ****
// port checks
// ****
module smc_standby_props
   import smc_pkg::*;
(
   input wire logic clk_sys, rst, reg_wr, nmi_req, irq_req, fetch_done,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic bus_hold_request, bus_hold_ack, cpu_clk_en, cpu_run,
   input wire logic fetch_en, periph_clk_en, main_osc_en, sub_osc_en,
   input wire logic sub_clk_en, uart_rx_en, twowire_serial_en,
   input wire logic timer_other_en, watch_timer_en, watchdog_en,
   input wire logic conv_dma_can_en, port_hold
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // halt keeps peripherals clocked, so a gated peripheral clock means idle
   wire logic idle = !periph_clk_en;
   sequence s_idle_wr;
      reg_wr && reg_addr == PWR_IDX && reg_wdata[PWR_IDLE_BIT] && cpu_run
         && periph_clk_en && !nmi_req && !irq_req;
   endsequence
   sequence s_wake;
      idle && (nmi_req || irq_req);
   endsequence
   property p_enter; s_idle_wr ##1 !irq_req |-> ##[0:1] idle; endproperty
   a_enter: assert property (p_enter) else $error("idle not entered");
   property p_wake; s_wake |=> cpu_clk_en && periph_clk_en; endproperty
   a_wake: assert property (p_wake) else $error("late wake");
   property p_hold_idle; idle |-> !bus_hold_ack; endproperty
   a_hold_idle: assert property (p_hold_idle)
      else $error("hold in idle");
   property p_osc; idle |-> main_osc_en && sub_osc_en && sub_clk_en;
   endproperty
   a_osc: assert property (p_osc) else $error("osc stopped");
   property p_freeze; idle |-> !cpu_clk_en && !cpu_run && !fetch_en;
   endproperty
   a_freeze: assert property (p_freeze) else $error("cpu runs");
   property p_periph;
      idle |-> !uart_rx_en && !twowire_serial_en && !timer_other_en;
   endproperty
   a_periph: assert property (p_periph)
      else $error("periph on");
   property p_keep;
      idle |-> watch_timer_en && !watchdog_en && !conv_dma_can_en && port_hold;
   endproperty
   a_keep: assert property (p_keep) else $error("idle set wrong");
   property p_ack;
      periph_clk_en && $past(periph_clk_en)
         |-> bus_hold_ack == $past(bus_hold_request);
   endproperty
   a_ack: assert property (p_ack) else $error("hold ack wrong");
   // the last fetch pulse fills the queue one edge before the freeze
   property p_drain;
      $fell(fetch_en) && periph_clk_en |-> $past(fetch_done, 2);
   endproperty
   a_drain: assert property (p_drain) else $error("early freeze");
endmodule : smc_standby_props
bind smc_standby_ctrl smc_standby_props smc_standby_props_i (.clk_sys,
   .rst, .reg_wr, .nmi_req, .irq_req, .fetch_done, .reg_addr, .reg_wdata,
   .bus_hold_request, .bus_hold_ack, .cpu_clk_en, .cpu_run, .fetch_en,
   .periph_clk_en, .main_osc_en, .sub_osc_en, .sub_clk_en, .uart_rx_en,
   .twowire_serial_en, .timer_other_en, .watch_timer_en, .watchdog_en,
   .conv_dma_can_en, .port_hold);

// File: test/smc_cpu_model.sv
// far side: core prefetch unit, one word per gap+1 cycles
`timescale 1ns/10ps
module smc_cpu_model
   import smc_pkg::*;
(
   clk_sys,
   rst,
   fetch_en,
   gap,
   fetch_done
);
   input wire logic clk_sys, rst, fetch_en;
   input wire logic [3:0] gap;
   output logic fetch_done;
   logic [3:0] cnt_r;
   // a large gap models a slow memory stalling the drain
   always_ff @(posedge clk_sys) begin
      if (rst || !fetch_en) begin
         cnt_r <= 4'h0;
         fetch_done <= 1'b0;
      end else begin
         fetch_done <= (cnt_r == gap);
         cnt_r <= (cnt_r == gap) ? 4'h0 : cnt_r + 4'h1;
      end
   end
endmodule : smc_cpu_model

// File: test/tb_smc_standby_ctrl.sv
// self-checking bench for the standby mode control block
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_smc_standby_ctrl
   import smc_pkg::*;
;
   logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic nmi_req = 1'b0, irq_req = 1'b0, bus_hold_request = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata;
   logic [3:0] gap = 4'h3;
   logic fetch_done, bus_hold_ack, cpu_clk_en, cpu_run, fetch_en;
   logic periph_clk_en, main_osc_en, sub_osc_en, sub_clk_en, ext_irq_six_en;
   logic timer_zero_en, timer_four_en, timer_five_en, timer_other_en;
   logic clocked_serial_port_en, twowire_serial_en, uart_tx_en, uart_rx_en;
   logic watch_timer_en, watchdog_en, conv_dma_can_en, port_hold;
   logic bus_pins_hiz;
   int miscompares = 0, num_checks = 0;
   // rows: clock select in, idle enables out
   logic [7:0] sel_tab [5] = '{8'h00, 8'hff, 8'h74, 8'h8c, 8'h30};
   logic [5:0] exp_tab [5] = '{6'h00, 6'h3f, 6'h38, 6'h07, 6'h00};
   logic [8:0] irq6_tab [4] = '{9'h006, 9'h017, 9'h010, 9'h001};
   wire logic [5:0] idle_vec = {timer_zero_en, timer_four_en, timer_five_en,
      clocked_serial_port_en, uart_tx_en, ext_irq_six_en};
   wire logic [9:0] idle_set = {timer_other_en, twowire_serial_en,
      uart_rx_en, watchdog_en, conv_dma_can_en, watch_timer_en, port_hold,
      main_osc_en, sub_osc_en, sub_clk_en};
   smc_standby_ctrl smc_standby_ctrl_i (.clk_sys, .rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nmi_req, .irq_req,
      .fetch_done, .bus_hold_request, .bus_hold_ack, .cpu_clk_en, .cpu_run,
      .fetch_en, .periph_clk_en, .main_osc_en, .sub_osc_en, .sub_clk_en,
      .ext_irq_six_en, .timer_zero_en, .timer_four_en, .timer_five_en,
      .timer_other_en, .clocked_serial_port_en, .twowire_serial_en,
      .uart_tx_en, .uart_rx_en, .watch_timer_en, .watchdog_en,
      .conv_dma_can_en, .port_hold, .bus_pins_hiz);
   smc_cpu_model smc_cpu_model_i (.clk_sys, .rst, .fetch_en, .gap,
      .fetch_done);
   always #25 clk_sys = ~clk_sys;
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   // ****
   // main sequence
   // ****
   initial begin
      logic [7:0] v;
      int k;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      bus_hold_request <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 `CHK(bus_hold_ack, 1'b1)
      wr(4'hf, 8'hff);
      rd(4'hf, v);
      `CHK(v, 8'h00)
      for (int i = 0; i < 5; i++) begin
         wr(CLKSEL_IDX, sel_tab[i]);
         rd(CLKSEL_IDX, v);
         `CHK(v, sel_tab[i])
         wr(PWR_IDX, 8'h01);
         repeat (2) @(posedge clk_sys);
         #1 `CHK(idle_vec, exp_tab[i])
         `CHK(idle_set, 10'h01f)
         `CHK({cpu_clk_en, periph_clk_en, bus_hold_ack}, 3'h0)
         rd(STAT_IDX, v);
         `CHK(v[1:0], 2'h3)
         @(posedge clk_sys);
         if (i[0]) nmi_req <= 1'b1;
         else irq_req <= 1'b1;
         @(posedge clk_sys);
         {nmi_req, irq_req} <= 2'h0;
         #1 `CHK({cpu_clk_en, periph_clk_en, cpu_run}, 3'h7)
         rd(PWR_IDX, v);
         `CHK(v, 8'h00)
      end
      // halt with a slow core: freeze only once the queue is full
      wr(PWR_IDX, 8'h02);
      repeat (2) @(posedge clk_sys);
      #1 `CHK(fetch_en, 1'b1)
      k = 0;
      while (fetch_en && k < 60) begin
         @(posedge clk_sys);
         #1 k++;
      end
      `CHK({cpu_clk_en, fetch_en, bus_pins_hiz, bus_hold_ack}, 4'h3)
      rd(STAT_IDX, v);
      // the fill count clears once halted; state field shows halt
      `CHK(v, 8'h02)
      for (int i = 0; i < 4; i++) begin
         wr(CLKSEL_IDX, irq6_tab[i][8:1]);
         repeat (2) @(posedge clk_sys);
         #1 `CHK(ext_irq_six_en, irq6_tab[i][0])
      end
      @(posedge clk_sys);
      nmi_req <= 1'b1;
      @(posedge clk_sys);
      nmi_req <= 1'b0;
      #1 `CHK({cpu_clk_en, fetch_en, bus_pins_hiz}, 3'h6)
      wr(PWR_IDX, 8'h01);
      repeat (2) @(posedge clk_sys);
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      #1 `CHK({cpu_clk_en, periph_clk_en}, 2'h3)
      summarize();
   end
   initial begin
      #100000;
      miscompares++;
      summarize();
   end
endmodule : tb_smc_standby_ctrl
